/* File: css_cfg.svh */
// Constants for the command source selector.
`ifndef CSS_CFG_SVH
`define CSS_CFG_SVH

// Register byte offsets
`define CSS_OFF_LINK_SEL   8'h00
`define CSS_OFF_FBUS_SEL   8'h04
`define CSS_OFF_LOCAL_CFG  8'h08
`define CSS_OFF_FREQ_SET   8'h0c
`define CSS_OFF_STATUS     8'h10

// Field positions
`define CSS_LCFG_FREQ_BIT  0
`define CSS_LCFG_ALT_BIT   1
`define CSS_LCFG_RUN_BIT   2
`define CSS_ST_FSRC_LSB    0
`define CSS_ST_RSRC_LSB    2
`define CSS_ST_RUN_BIT     4
`define CSS_ST_REJ_BIT     5
`define CSS_ST_FCMD_LSB    16

// Code limits
`define CSS_LINK_MAX       4'h8
`define CSS_FBUS_MAX       4'h3

// Reset values
`define CSS_RST_LINK       4'h0
`define CSS_RST_FBUS       4'h0
`define CSS_RST_LCFG       3'h0
`define CSS_RST_FSET       16'h0000

// Bus responses
`define CSS_RESP_OKAY      2'h0
`define CSS_RESP_SLVERR    2'h2

`endif

/* File: css_pkg.sv */
// Types for the command source selector.
package css_pkg;

   typedef enum logic [1:0] {
      CSS_SRC_LOCAL,
      CSS_SRC_STD485,
      CSS_SRC_OPT485,
      CSS_SRC_FBUS
   } css_src_t;

   typedef struct packed {
      logic        aw_got;
      logic [7:0]  aw_addr;
      logic        w_got;
      logic [31:0] w_data;
      logic [3:0]  w_strb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic [3:0]  link;
      logic [3:0]  fbus;
      logic [2:0]  lcfg;
      logic [15:0] fset;
      logic        reject;
      logic        term_s1;
      logic        term_s2;
      logic [15:0] freq_cmd;
      logic        run_cmd;
      css_src_t    freq_src;
      css_src_t    run_src;
      logic [31:0] rb_data;
   } css_state_t;

endpackage : css_pkg

/* File: css_remote_host.sv */
// Remote host model: command values per link and register readback.
`timescale 1ns/1ps
module css_remote_host (
   input  wire logic        ref_clk,
   output logic [15:0]      std485_freq,
   output logic             std485_run,
   output logic [15:0]      opt485_freq,
   output logic             opt485_run,
   output logic [15:0]      fieldbus_freq,
   output logic             fieldbus_run,
   output logic [7:0]       remote_rb_addr,
   input  wire logic [31:0] remote_rb_data
);
   // Distinct frequency values per path, so a wrong pick shows; run values of std485 and fieldbus are both 0
   assign std485_freq   = 16'h2222;
   assign std485_run    = 1'b0;
   assign opt485_freq   = 16'h3333;
   assign opt485_run    = 1'b1;
   assign fieldbus_freq = 16'h4444;
   assign fieldbus_run  = 1'b0;
   initial remote_rb_addr = 8'h00;

   // Readback: address held, data taken two edges later
   task automatic rb(input logic [7:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      remote_rb_addr <= a;
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
      d = remote_rb_data;
      @(posedge ref_clk);
   endtask : rb
endmodule : css_remote_host

/* File: css_src_decode.sv */
// Decoder from selection codes to command sources.
`timescale 1ns/1ps
module css_src_decode
   import css_pkg::*;
(
   input  wire logic [3:0] link_command_source_select,
   input  wire logic [3:0] fieldbus_command_source_select,
   output css_src_t        freq_src,
   output css_src_t        run_src
);

   css_src_t link_freq;
   css_src_t link_run;

   // Link code tables, then field-bus override per command
   always_comb begin
      case (link_command_source_select)
         4'h1, 4'h3, 4'h7: link_freq = CSS_SRC_STD485;
         4'h4, 4'h5, 4'h8: link_freq = CSS_SRC_OPT485;
         default:          link_freq = CSS_SRC_LOCAL;
      endcase
      case (link_command_source_select)
         4'h2, 4'h3, 4'h5: link_run = CSS_SRC_STD485;
         4'h6, 4'h7, 4'h8: link_run = CSS_SRC_OPT485;
         default:          link_run = CSS_SRC_LOCAL;
      endcase
      // Bit 0 claims frequency, bit 1 claims run
      freq_src = fieldbus_command_source_select[0] ? CSS_SRC_FBUS
                                                   : link_freq;
      run_src  = fieldbus_command_source_select[1] ? CSS_SRC_FBUS
                                                   : link_run;
   end

endmodule : css_src_decode

/* File: css_top.sv */
// Command source selector with AXI4-Lite configuration port.
`timescale 1ns/1ps
`include "css_cfg.svh"
module css_top
   import css_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        reset_n,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic [15:0] local_freq_in,
   input  wire logic [15:0] alt_freq_in,
   input  wire logic        multistep_active,
   input  wire logic [15:0] multistep_freq,
   input  wire logic        keypad_run,
   input  wire logic        terminal_run_pin,
   input  wire logic [15:0] std485_freq,
   input  wire logic        std485_run,
   input  wire logic [15:0] opt485_freq,
   input  wire logic        opt485_run,
   input  wire logic [15:0] fieldbus_freq,
   input  wire logic        fieldbus_run,
   input  wire logic [7:0]  remote_rb_addr,
   output logic [31:0]      remote_rb_data,
   output logic [15:0]      freq_cmd,
   output logic             run_cmd,
   output css_src_t         freq_src,
   output css_src_t         run_src
);

   css_state_t st_reg;
   css_state_t st_next;
   css_src_t   dec_freq;
   css_src_t   dec_run;
   logic       wr_fire;
   logic       rej_set;
   logic       rej_clr;
   logic [15:0] local_freq;
   logic [32:0] rd_hit;

   // Register read mux shared by bus and remote readback
   function automatic logic [32:0] css_rd(input logic [7:0] addr,
                                          input css_state_t s);
      logic [31:0] d;
      logic        hit;
      d   = 32'h00000000;
      hit = 1'b1;
      case (addr)
         `CSS_OFF_LINK_SEL:  d[3:0]  = s.link;
         `CSS_OFF_FBUS_SEL:  d[3:0]  = s.fbus;
         `CSS_OFF_LOCAL_CFG: d[2:0]  = s.lcfg;
         `CSS_OFF_FREQ_SET:  d[15:0] = s.fset;
         `CSS_OFF_STATUS: begin
            d[`CSS_ST_FSRC_LSB +: 2]  = s.freq_src;
            d[`CSS_ST_RSRC_LSB +: 2]  = s.run_src;
            d[`CSS_ST_RUN_BIT]        = s.run_cmd;
            d[`CSS_ST_REJ_BIT]        = s.reject;
            d[`CSS_ST_FCMD_LSB +: 16] = s.freq_cmd;
         end
         default: hit = 1'b0;
      endcase
      return {hit, d};
   endfunction : css_rd

   // Source decode from the held codes
   css_src_decode u_decode (
      .link_command_source_select     (st_reg.link),
      .fieldbus_command_source_select (st_reg.fbus),
      .freq_src                       (dec_freq),
      .run_src                        (dec_run)
   );

   // Bus handshakes and outputs
   assign s_axi_awready  = !st_reg.aw_got;
   assign s_axi_wready   = !st_reg.w_got;
   assign s_axi_bvalid   = st_reg.bvalid;
   assign s_axi_bresp    = st_reg.bresp;
   assign s_axi_arready  = !st_reg.rvalid;
   assign s_axi_rvalid   = st_reg.rvalid;
   assign s_axi_rdata    = st_reg.rdata;
   assign s_axi_rresp    = st_reg.rresp;
   assign remote_rb_data = st_reg.rb_data;
   assign freq_cmd       = st_reg.freq_cmd;
   assign run_cmd        = st_reg.run_cmd;
   assign freq_src       = st_reg.freq_src;
   assign run_src        = st_reg.run_src;
   assign wr_fire = st_reg.aw_got && st_reg.w_got && !st_reg.bvalid;

   // Next state of the whole block
   always_comb begin
      st_next = st_reg;
      rej_set = 1'b0;
      rej_clr = 1'b0;
      // Address and data are taken independently
      if (s_axi_awvalid && !st_reg.aw_got) begin
         st_next.aw_got  = 1'b1;
         st_next.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !st_reg.w_got) begin
         st_next.w_got  = 1'b1;
         st_next.w_data = s_axi_wdata;
         st_next.w_strb = s_axi_wstrb;
      end
      if (st_reg.bvalid && s_axi_bready) begin
         st_next.bvalid = 1'b0;
      end
      // Register write once both halves are held
      if (wr_fire) begin
         st_next.aw_got = 1'b0;
         st_next.w_got  = 1'b0;
         st_next.bvalid = 1'b1;
         st_next.bresp  = `CSS_RESP_OKAY;
         case (st_reg.aw_addr)
            `CSS_OFF_LINK_SEL: if (st_reg.w_strb[0]) begin
               if (st_reg.w_data[3:0] <= `CSS_LINK_MAX) begin
                  st_next.link = st_reg.w_data[3:0];
               end else begin
                  rej_set = 1'b1;
               end
            end
            `CSS_OFF_FBUS_SEL: if (st_reg.w_strb[0]) begin
               if (st_reg.w_data[3:0] <= `CSS_FBUS_MAX) begin
                  st_next.fbus = st_reg.w_data[3:0];
               end else begin
                  rej_set = 1'b1;
               end
            end
            `CSS_OFF_LOCAL_CFG: if (st_reg.w_strb[0]) begin
               st_next.lcfg = st_reg.w_data[2:0];
            end
            `CSS_OFF_FREQ_SET: begin
               if (st_reg.w_strb[0]) begin
                  st_next.fset[7:0] = st_reg.w_data[7:0];
               end
               if (st_reg.w_strb[1]) begin
                  st_next.fset[15:8] = st_reg.w_data[15:8];
               end
            end
            `CSS_OFF_STATUS: begin
               rej_clr = st_reg.w_strb[0] && st_reg.w_data[`CSS_ST_REJ_BIT];
            end
            default: st_next.bresp = `CSS_RESP_SLVERR;
         endcase
      end
      // Refusal flag, a new refusal beats the clear
      st_next.reject = (st_reg.reject && !rej_clr) || rej_set;
      // Read channel
      if (st_reg.rvalid && s_axi_rready) begin
         st_next.rvalid = 1'b0;
      end
      if (s_axi_arvalid && !st_reg.rvalid) begin
         rd_hit         = css_rd(s_axi_araddr, st_reg);
         st_next.rvalid = 1'b1;
         st_next.rdata  = rd_hit[31:0];
         st_next.rresp  = rd_hit[32] ? `CSS_RESP_OKAY : `CSS_RESP_SLVERR;
      end
      // Remote readback of status and settings
      rd_hit          = css_rd(remote_rb_addr, st_reg);
      st_next.rb_data = rd_hit[31:0];
      // Terminal pin synchroniser
      st_next.term_s1 = terminal_run_pin;
      st_next.term_s2 = st_reg.term_s1;
      // Local frequency: multi-step first, then the selected setting
      if (multistep_active) begin
         local_freq = multistep_freq;
      end else if (st_reg.lcfg[`CSS_LCFG_ALT_BIT]) begin
         local_freq = alt_freq_in;
      end else if (st_reg.lcfg[`CSS_LCFG_FREQ_BIT]) begin
         local_freq = local_freq_in;
      end else begin
         local_freq = st_reg.fset;
      end
      // Frequency command mux
      case (dec_freq)
         CSS_SRC_STD485: st_next.freq_cmd = std485_freq;
         CSS_SRC_OPT485: st_next.freq_cmd = opt485_freq;
         CSS_SRC_FBUS:   st_next.freq_cmd = fieldbus_freq;
         default:        st_next.freq_cmd = local_freq;
      endcase
      // Run command mux
      case (dec_run)
         CSS_SRC_STD485: st_next.run_cmd = std485_run;
         CSS_SRC_OPT485: st_next.run_cmd = opt485_run;
         CSS_SRC_FBUS:   st_next.run_cmd = fieldbus_run;
         default: st_next.run_cmd = st_reg.lcfg[`CSS_LCFG_RUN_BIT] ?
                                    st_reg.term_s2 : keypad_run;
      endcase
      st_next.freq_src = dec_freq;
      st_next.run_src  = dec_run;
   end

   // State register with synchronous reset
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         st_reg      <= '0;
         st_reg.link <= `CSS_RST_LINK;
         st_reg.fbus <= `CSS_RST_FBUS;
         st_reg.lcfg <= `CSS_RST_LCFG;
         st_reg.fset <= `CSS_RST_FSET;
      end else begin
         st_reg <= st_next;
      end
   end

   // Checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   sequence s_bad_link_wr;
      wr_fire && st_reg.aw_addr == `CSS_OFF_LINK_SEL && st_reg.w_strb[0]
         && st_reg.w_data[3:0] > `CSS_LINK_MAX;
   endsequence

   sequence s_rb_link;
      remote_rb_addr == `CSS_OFF_LINK_SEL;
   endsequence

   property p_local_multistep;
      dec_freq == CSS_SRC_LOCAL && multistep_active
         |=> freq_cmd == $past(multistep_freq);
   endproperty
   a_local_multistep: assert property (p_local_multistep)
      else $error("local multi-step frequency not taken");

   property p_local_run;
      dec_run == CSS_SRC_LOCAL && st_reg.lcfg[`CSS_LCFG_RUN_BIT] == 1'b0
         |=> run_cmd == $past(keypad_run);
   endproperty
   a_local_run: assert property (p_local_run)
      else $error("keypad run not taken");

   property p_std_freq;
      dec_freq == CSS_SRC_STD485 |=> freq_cmd == $past(std485_freq);
   endproperty
   a_std_freq: assert property (p_std_freq)
      else $error("standard link frequency not taken");

   property p_link_freq_map;
      st_reg.fbus == 4'h0 && st_reg.link inside {4'h4, 4'h5, 4'h8}
         |=> freq_src == CSS_SRC_OPT485;
   endproperty
   a_link_freq_map: assert property (p_link_freq_map)
      else $error("option card frequency code mapped wrongly");

   property p_link_run_map;
      st_reg.fbus == 4'h0 && st_reg.link inside {4'h0, 4'h1, 4'h4}
         |=> run_src == CSS_SRC_LOCAL;
   endproperty
   a_link_run_map: assert property (p_link_run_map)
      else $error("local run code mapped wrongly");

   property p_fbus_both;
      st_reg.fbus == 4'h3
         |=> freq_src == CSS_SRC_FBUS && run_src == CSS_SRC_FBUS;
   endproperty
   a_fbus_both: assert property (p_fbus_both)
      else $error("field bus did not claim both commands");

   property p_fbus_freq_only;
      st_reg.fbus == 4'h1 && st_reg.link inside {4'h2, 4'h3, 4'h5}
         |=> freq_src == CSS_SRC_FBUS && run_src == CSS_SRC_STD485;
   endproperty
   a_fbus_freq_only: assert property (p_fbus_freq_only)
      else $error("run command not resolved from link code");

   property p_rb_link;
      s_rb_link |=> remote_rb_data == {28'h0000000, $past(st_reg.link)};
   endproperty
   a_rb_link: assert property (p_rb_link)
      else $error("remote readback wrong");

   property p_fbus_data;
      dec_run == CSS_SRC_FBUS |=> run_cmd == $past(fieldbus_run);
   endproperty
   a_fbus_data: assert property (p_fbus_data)
      else $error("field bus run not taken");

   property p_reject;
      s_bad_link_wr |=> $stable(st_reg.link) && st_reg.reject;
   endproperty
   a_reject: assert property (p_reject)
      else $error("out of range link code accepted");

endmodule : css_top

/* File: css_top_tb.sv */
// Self-checking bench for the command source selector.
`timescale 1ns/1ps
`include "css_cfg.svh"
module css_top_tb
   import css_pkg::*;
;
   logic        ref_clk = 1'b0, reset_n = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, remote_rb_data, d;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
   logic        s_axi_rready = 1'b0, terminal_run_pin = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic        s_axi_rvalid, run_cmd, std485_run, opt485_run, fieldbus_run;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
   logic [15:0] local_freq_in = 16'h5555, freq_cmd, fv [4];
   logic [15:0] std485_freq, opt485_freq, fieldbus_freq;
   logic        keypad_run = 1'b1;
   logic        multistep_active = 1'b0;
   logic [7:0]  remote_rb_addr;
   css_src_t    freq_src, run_src;
   int          n_mismatch = 0, compares = 0;

   css_top u_css_top (.ref_clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .local_freq_in,
      .alt_freq_in(16'h6666), .multistep_active,
      .multistep_freq(16'h7777), .keypad_run, .terminal_run_pin,
      .std485_freq, .std485_run, .opt485_freq, .opt485_run,
      .fieldbus_freq, .fieldbus_run, .remote_rb_addr, .remote_rb_data,
      .freq_cmd, .run_cmd, .freq_src, .run_src);
   css_remote_host u_css_remote_host (.ref_clk, .std485_freq, .std485_run,
      .opt485_freq, .opt485_run, .fieldbus_freq, .fieldbus_run,
      .remote_rb_addr, .remote_rb_data);

   // Free-running 100 MHz clock
   always #5 ref_clk = ~ref_clk;

   task automatic summarize();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : summarize

   task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   // Write: both channels offered, each released when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic aw, w, ta, tw, b;
      int n;
      aw = 1;
      w = 1;
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(negedge ref_clk);
         ta = aw && s_axi_awready;
         tw = w && s_axi_wready;
         b = s_axi_bvalid;
         rsp = s_axi_bresp;
         @(posedge ref_clk);
         if (ta) begin
            aw = 0;
            s_axi_awvalid <= 1'b0;
         end
         if (tw) begin
            w = 0;
            s_axi_wvalid <= 1'b0;
         end
         if (b) break;
      end
      s_axi_bready <= 1'b0;
      @(posedge ref_clk); // Idle edge before the next request
      if (n == 50) begin
         n_mismatch++;
         summarize();
      end
   endtask : wr

   // Read: address held until taken, data taken with rvalid
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      logic ar, ta, r;
      int n;
      ar = 1;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(negedge ref_clk);
         ta = ar && s_axi_arready;
         r = s_axi_rvalid;
         v = s_axi_rdata;
         rsp = s_axi_rresp;
         @(posedge ref_clk);
         if (ta) begin
            ar = 0;
            s_axi_arvalid <= 1'b0;
         end
         if (r) break;
      end
      s_axi_rready <= 1'b0;
      @(posedge ref_clk); // Idle edge before the next request
      if (n == 50) begin
         n_mismatch++;
         summarize();
      end
   endtask : rd

   // Expected source from link and field-bus codes
   function automatic logic [1:0] src_exp(int l, int f, bit run);
      if (run ? f[1] : f[0])
         return 2'h3;
      if (run)
         return (l inside {2, 3, 5}) ? 2'h1 : (l >= 6) ? 2'h2 : 2'h0;
      return (l inside {1, 3, 7}) ? 2'h1 : (l inside {4, 5, 8}) ? 2'h2
         : 2'h0;
   endfunction : src_exp

   initial begin
      fv = '{16'h1234, 16'h2222, 16'h3333, 16'h4444};
      repeat (12) @(posedge ref_clk);
      reset_n <= 1'b1;
      @(posedge ref_clk);
      rd(`CSS_OFF_STATUS, d);
      chk("status reset", d, 32'h00000010);
      $display("test reset done");
      // Every link code against every override code
      wr(`CSS_OFF_FREQ_SET, 32'h1234);
      for (int l = 0; l <= 8; l++)
         for (int f = 0; f <= 3; f++) begin
            wr(`CSS_OFF_LINK_SEL, l);
            wr(`CSS_OFF_FBUS_SEL, f);
            repeat (3) @(posedge ref_clk);
            chk("freq_src", freq_src, src_exp(l, f, 0));
            chk("run_src", run_src, src_exp(l, f, 1));
            chk("freq_cmd", freq_cmd, fv[src_exp(l, f, 0)]);
            chk("run_cmd", run_cmd,
                src_exp(l, f, 1) inside {2'h0, 2'h2});
         end
      $display("test source map done");
      // Codes out of range keep the last good one
      wr(`CSS_OFF_LINK_SEL, 32'h3);
      wr(`CSS_OFF_LINK_SEL, 32'h9);
      chk("bresp range", rsp, `CSS_RESP_OKAY);
      rd(`CSS_OFF_LINK_SEL, d);
      chk("link kept", d[3:0], 4'h3);
      wr(`CSS_OFF_FBUS_SEL, 32'h4);
      rd(`CSS_OFF_FBUS_SEL, d);
      chk("fbus kept", d[3:0], 4'h3);
      rd(`CSS_OFF_STATUS, d);
      chk("reject set", d[5], 1'b1);
      wr(`CSS_OFF_STATUS, 32'h20);
      rd(`CSS_OFF_STATUS, d);
      chk("reject clr", d[5], 1'b0);
      $display("test range done");
      // Unmapped place answers with an error
      rd(8'h40, d);
      chk("rresp bad", rsp, `CSS_RESP_SLVERR);
      wr(8'h40, 32'h1);
      chk("bresp bad", rsp, `CSS_RESP_SLVERR);
      // Remote readback of code and status
      u_css_remote_host.rb(`CSS_OFF_LINK_SEL, d);
      chk("rb link", d[3:0], 4'h3);
      u_css_remote_host.rb(`CSS_OFF_STATUS, d);
      chk("rb fsrc", d[1:0], 2'h3);
      $display("test readback done");
      // Local sources: local frequency input, keypad, terminal
      wr(`CSS_OFF_FBUS_SEL, 32'h0);
      wr(`CSS_OFF_LINK_SEL, 32'h0);
      wr(`CSS_OFF_LOCAL_CFG, 32'h1);
      repeat (3) @(posedge ref_clk);
      chk("local freq", freq_cmd, 16'h5555);
      chk("keypad run", run_cmd, 1'b1);
      wr(`CSS_OFF_LOCAL_CFG, 32'h4);
      repeat (3) @(posedge ref_clk);
      chk("term off", run_cmd, 1'b0);
      terminal_run_pin <= 1'b1;
      repeat (5) @(posedge ref_clk);
      chk("term on", run_cmd, 1'b1);
      // Alternate setting, then multi-step over it
      wr(`CSS_OFF_LOCAL_CFG, 32'h2);
      repeat (3) @(posedge ref_clk);
      chk("alt freq", freq_cmd, 16'h6666);
      multistep_active <= 1'b1;
      repeat (3) @(posedge ref_clk);
      chk("multistep freq", freq_cmd, 16'h7777);
      multistep_active <= 1'b0;
      repeat (3) @(posedge ref_clk);
      chk("alt again", freq_cmd, 16'h6666);
      $display("test local done");
      summarize();
   end
endmodule : css_top_tb
